//--- rsc_pkg.sv
// Purpose: Shared constants for the reset source controller.
// Assumes: System clock ref_clk at 100 MHz.
// Notes:   Cause register bit positions and delay counts live here.
package rsc_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_NS          = 10;      // 100 MHz
    localparam int POR_DELAY_US           = 300;     // Power-on release delay, 0.3 ms
    localparam int POR_DELAY_CYC          = (POR_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int WDT_DIV                = 12;      // Watchdog prescale ratio
    localparam int SYNC_STAGES            = 2;       // Pin input synchroniser depth

    // ==========================================================
    // Cause register layout and reset values
    // ==========================================================
    localparam int          PIN_FLAG_BIT  = 0;       // Pin reset flag position
    localparam int          POR_FLAG_BIT  = 1;       // Power-on flag position
    localparam int          MON_FLAG_BIT  = 2;       // Supply-monitor flag position
    localparam logic [7:0]  CAUSE_RST     = 8'h00;   // Cause register after reset
    localparam logic [7:0]  PORT_RST      = 8'hff;   // Port latch value in reset
    localparam logic [15:0] PC_RST        = 16'h0000; // Fetch address on exit

    // ==========================================================
    // Sequencer states
    // ==========================================================
    typedef enum logic [1:0] {
        RSC_ST_HOLD,      // Reset asserted, waiting for supply/pin
        RSC_ST_DELAY,     // Power-on release delay running
        RSC_ST_RUN        // Core released
    } rsc_state_e;

endpackage : rsc_pkg

//--- rsc_sync.sv
// Purpose: Two flip-flop synchroniser for one external level.
// Assumes: Input is asynchronous to ref_clk.
// Notes:   First stage is read only by the second stage.
module rsc_sync #(
    parameter logic RST_VAL = 1'b0     // Value held while in reset
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;                      // First stage, metastability catch

    // ==========================================================
    // Two stage capture
    // ==========================================================
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // rsc_sync

//--- rsc_reset_source_controller.sv
// Purpose: Reset sequencer: sources, release timing, cause flags, core state.
// Assumes: Supply monitor and power-on detector give raw async levels.
// Notes:   No software registers; cause register is a plain output.

// Functional notes
// - Reset halts core, resets registers, timers, interrupts
// - Data memory kept; stack pointer reinitialised
// - Port latches all ones, open-drain, pullups on
// - Drive reset pin low for monitor/power-on
// - Program counter zero on exit
// - Internal oscillator selected on exit
// - Watchdog enabled, clock divided by twelve
// - Power-on waits threshold then release delay
// - Power-on sets flag bit one
// - Other causes clear the power-on flag
// - Supply monitor disabled after power-on
// - Pin reset sets flag bit zero
// - Monitor reset releases without extra delay
module rsc_reset_source_controller #(
    parameter int POR_DELAY = rsc_pkg::POR_DELAY_CYC   // Power-on delay in cycles
) (
    // Clock, reset and enable
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // Reset sources, asynchronous
    input  wire logic        supply_ok,       // Supply above reset_threshold
    input  wire logic        por_det,         // Power-on detector active
    input  wire logic        rst_pin_in,      // Reset pin level, active low
    // Supply monitor enable from software side
    input  wire logic        mon_en_set,      // Pulse: software enables monitor
    input  wire logic        mon_en_clr,      // Pulse: software disables monitor
    // Reset pin drive
    output logic             rst_pin_out,     // Driven level (always low)
    output logic             rst_pin_oe_n,    // Low while pin is driven
    // Core and system controls
    output logic             core_run,        // Core may execute
    output logic             regs_rst,        // Reset all special function registers
    output logic             irq_tmr_dis,     // Interrupts and timers disabled
    output logic             sp_rst,          // Stack pointer reload only
    output logic             mem_hold,        // Data memory write inhibit, keeps contents
    output logic [15:0]      pc_init,         // Fetch start address
    output logic             osc_int_sel,     // Internal oscillator chosen
    output logic             wdt_en,          // Watchdog enable
    output logic             wdt_tick,        // Watchdog prescaler tick
    output logic [7:0]       port_latch,      // Port output latch value
    output logic             port_od,         // Open-drain mode for ports
    output logic             port_pullup,     // Weak pullups enabled
    output logic             mon_en,          // Supply monitor enable
    output logic [7:0]       reset_cause_register // Cause flags
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (POR_DELAY < 1) begin : g_bad_delay
        $error("POR_DELAY must be at least one cycle");
    end
    localparam int DW = $clog2(POR_DELAY + 1);   // Delay counter width
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic supply_s;                   // Supply good, synchronised
    logic por_s;                      // Power-on detect, synchronised
    logic pin_s;                      // Pin level, synchronised
    rsc_sync #(.RST_VAL(1'b0)) u_sync_sup (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in (supply_ok),
        .sync_out (supply_s)
    );
    rsc_sync #(.RST_VAL(1'b1)) u_sync_por (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in (por_det),
        .sync_out (por_s)
    );
    rsc_sync #(.RST_VAL(1'b1)) u_sync_pin (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in (rst_pin_in),
        .sync_out (pin_s)
    );

    // ==========================================================
    // State
    // ==========================================================
    rsc_pkg::rsc_state_e st_q, st_d;  // Sequencer state
    logic [DW-1:0] cnt_q, cnt_d;      // Release delay counter
    logic          por_q, por_d;      // Power-on reset in progress
    logic          pin_q, pin_d;      // Pin reset in progress
    logic          mon_q, mon_d;      // Monitor reset in progress
    logic [7:0]    cause_q, cause_d;  // Cause flags
    logic          men_q, men_d;      // Supply monitor enable
    logic [3:0]    div_q, div_d;      // Watchdog divide counter
    logic          tick_q, tick_d;    // Watchdog tick
    logic          run_q, run_d;      // Core released
    logic [1:0]    echo_q, echo_d;    // Own pin drive history, one bit per sync stage
    logic mon_trip;                   // Monitor-selected supply failure
    logic pin_act;                    // Pin pulled low externally
    // Pin reads our own drive too, and the synchroniser shows our release late;
    // the history hides that echo so a self-driven low is never a pin cause
    assign mon_trip = men_q && !supply_s;
    assign pin_act  = !pin_s && run_q && echo_q[rsc_pkg::SYNC_STAGES-1];

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        por_d   = por_q;
        pin_d   = pin_q;
        mon_d   = mon_q;
        cause_d = cause_q;
        men_d   = men_q;
        run_d   = run_q;
        div_d   = div_q;
        tick_d  = 1'b0;
        echo_d  = {echo_q[0], rst_pin_oe_n};   // Drive level seen by the pin
        // Software enable of monitor; set wins over clear
        men_d   = mon_en_set || (men_q && !mon_en_clr);
        unique case (st_q)
            rsc_pkg::RSC_ST_HOLD: begin
                run_d = 1'b0;
                por_d = por_q || por_s;
                // Hold until supply good, power-on detect gone and, after a pin reset, pin released
                if (supply_s && !por_s && (pin_s || !pin_q)) begin
                    if (por_q || por_s) begin
                        st_d  = rsc_pkg::RSC_ST_DELAY;
                        cnt_d = '0;
                    end else begin
                        st_d  = rsc_pkg::RSC_ST_RUN;
                        run_d = 1'b1;
                    end
                end
            end
            rsc_pkg::RSC_ST_DELAY: begin
                // Counter stops at POR_DELAY at most, which DW still holds
                cnt_d = cnt_q + DW'(1);
                if (por_s || !supply_s) begin
                    st_d = rsc_pkg::RSC_ST_HOLD;
                end else if (cnt_q == DW'(POR_DELAY - 1)) begin
                    st_d  = rsc_pkg::RSC_ST_RUN;
                    run_d = 1'b1;
                end
            end
            rsc_pkg::RSC_ST_RUN: begin
                if (por_s || pin_act || mon_trip) begin
                    st_d  = rsc_pkg::RSC_ST_HOLD;
                    run_d = 1'b0;
                    por_d = por_s;
                    pin_d = pin_act && !por_s;
                    mon_d = mon_trip && !por_s;
                end
            end
            default: begin
                st_d = rsc_pkg::RSC_ST_HOLD;
            end
        endcase
        // Flags latched on the release edge
        if (st_q != rsc_pkg::RSC_ST_RUN && st_d == rsc_pkg::RSC_ST_RUN) begin
            cause_d = rsc_pkg::CAUSE_RST;
            if (por_q) begin
                cause_d[rsc_pkg::POR_FLAG_BIT] = 1'b1;
                men_d = 1'b0;
            end else begin
                cause_d[rsc_pkg::POR_FLAG_BIT] = 1'b0;
                cause_d[rsc_pkg::PIN_FLAG_BIT] = pin_q;
                cause_d[rsc_pkg::MON_FLAG_BIT] = mon_q;
            end
            por_d = 1'b0;
            pin_d = 1'b0;
            mon_d = 1'b0;
        end
        // Watchdog prescaler runs only while core runs
        if (run_q) begin
            if (div_q == 4'(rsc_pkg::WDT_DIV - 1)) begin
                div_d  = '0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 4'h1;
            end
        end else begin
            div_d = '0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q    <= rsc_pkg::RSC_ST_HOLD;
            cnt_q   <= '0;
            por_q   <= 1'b1;
            pin_q   <= 1'b0;
            mon_q   <= 1'b0;
            cause_q <= rsc_pkg::CAUSE_RST;
            men_q   <= 1'b0;
            div_q   <= '0;
            tick_q  <= 1'b0;
            run_q   <= 1'b0;
            echo_q  <= '0;
        end else if (clk_en) begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            por_q   <= por_d;
            pin_q   <= pin_d;
            mon_q   <= mon_d;
            cause_q <= cause_d;
            men_q   <= men_d;
            div_q   <= div_d;
            tick_q  <= tick_d;
            run_q   <= run_d;
            echo_q  <= echo_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    // ==========================================================
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pin_out          <= 1'b0;
            rst_pin_oe_n         <= 1'b0;
            core_run             <= 1'b0;
            regs_rst             <= 1'b1;
            irq_tmr_dis          <= 1'b1;
            sp_rst               <= 1'b1;
            mem_hold             <= 1'b1;
            pc_init              <= rsc_pkg::PC_RST;
            osc_int_sel          <= 1'b1;
            wdt_en               <= 1'b0;
            wdt_tick             <= 1'b0;
            port_latch           <= rsc_pkg::PORT_RST;
            port_od              <= 1'b1;
            port_pullup          <= 1'b1;
            mon_en               <= 1'b0;
            reset_cause_register <= rsc_pkg::CAUSE_RST;
        end else if (clk_en) begin
            rst_pin_out  <= 1'b0;
            // Drive pin low only for power-on and monitor resets
            rst_pin_oe_n <= !(!run_d && (por_d || mon_d));
            core_run     <= run_d;
            regs_rst     <= !run_d;
            irq_tmr_dis  <= !run_d;
            sp_rst       <= !run_d;
            mem_hold     <= !run_d;
            pc_init      <= rsc_pkg::PC_RST;
            osc_int_sel  <= !run_d ? 1'b1 : osc_int_sel;
            wdt_en       <= run_d;
            wdt_tick     <= tick_d;
            if (!run_d) begin
                port_latch <= rsc_pkg::PORT_RST;
                port_od    <= 1'b1;
            end
            port_pullup          <= 1'b1;
            mon_en               <= men_d;
            reset_cause_register <= cause_d;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_pin_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && !core_run && por_q) |-> !rst_pin_oe_n)
        else $error("reset pin not driven during power-on reset");
    chk_por_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && $rose(core_run) && $past(por_q)) |->
        reset_cause_register[rsc_pkg::POR_FLAG_BIT])
        else $error("power-on flag not set on exit");
    chk_por_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && $rose(core_run) && !$past(por_q)) |->
        !reset_cause_register[rsc_pkg::POR_FLAG_BIT])
        else $error("power-on flag kept after other reset");
    chk_pin_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && $rose(core_run) && $past(pin_q) && !$past(por_q)) |->
        reset_cause_register[rsc_pkg::PIN_FLAG_BIT])
        else $error("pin flag not set after pin reset");
    chk_mon_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && $rose(core_run) && $past(por_q) && !$past(mon_en_set)) |-> !mon_en)
        else $error("monitor enabled after power-on");
    chk_ports: assert property (@(posedge ref_clk) disable iff (!rstn)
        !core_run |-> (port_latch == rsc_pkg::PORT_RST && port_od && port_pullup))
        else $error("ports not in reset state");
    chk_core_halt: assert property (@(posedge ref_clk) disable iff (!rstn)
        !core_run |-> (regs_rst && irq_tmr_dis && !wdt_en))
        else $error("core controls wrong during reset");
    chk_mon_fast: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && st_q == rsc_pkg::RSC_ST_HOLD && !por_q && !por_s && supply_s
         && !pin_q) |=> (st_q == rsc_pkg::RSC_ST_RUN || !$past(clk_en)))
        else $error("monitor reset took power-on delay");
    chk_pc_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(core_run) |-> pc_init == rsc_pkg::PC_RST)
        else $error("fetch address not zero");

endmodule // rsc_reset_source_controller

//--- rsc_supply_model.sv
// Purpose: Far-side model: supply monitor, power-on detector and reset pin.
// Assumes: Bench steers supply presence, sag and external pin press.
// Notes:   Pin has a pull-up, so a released pin reads high, never stale.
module rsc_supply_model #(
    parameter int RAMP = 5             // Cycles for supply to reach threshold
) (
    // Clock
    input  wire logic ref_clk,
    // Scenario controls
    input  wire logic pwr_on,          // Supply applied
    input  wire logic sag,             // Supply dips below threshold
    input  wire logic ext_low,         // External circuit pulls pin low
    // Device pin drive
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe_n,
    // Levels toward the device
    output logic      supply_ok,
    output logic      por_det,
    output logic      rst_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Supply ramp
    // ==========================================================
    int ramp_cnt = 0;                  // Cycles since supply applied

    // Ramp counter restarts whenever supply is removed
    always @(posedge ref_clk) begin
        if (!pwr_on) begin
            ramp_cnt <= 0;
        end else if (ramp_cnt < RAMP) begin
            ramp_cnt <= ramp_cnt + 1;
        end
    end

    // Detector active only while ramping
    assign por_det   = pwr_on && (ramp_cnt < RAMP);
    // Threshold crossed once ramp done, lost at once on a sag
    assign supply_ok = pwr_on && (ramp_cnt >= RAMP) && !sag;

    // ==========================================================
    // Reset pin wire
    // ==========================================================
    // Wired-and of both drivers over the pull-up
    assign rst_pin_in = !(ext_low || (!rst_pin_oe_n && !rst_pin_out));
endmodule // rsc_supply_model

//--- tb_top.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: Short power-on delay parameter, far-side model in its own file.
// Notes:   Table rows cover pin and monitor resets; hand tests follow.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    // ==========================================================
    localparam int PD = 20;            // Shortened power-on delay
    typedef struct {logic mon; logic [7:0] cause; logic oe_n;} rsc_row_s;
    logic ref_clk, rstn, clk_en, mon_en_set, mon_en_clr, pwr_on, sag, ext_low;
    logic supply_ok, por_det, rst_pin_in, rst_pin_out, rst_pin_oe_n, core_run;
    logic regs_rst, irq_tmr_dis, sp_rst, mem_hold, osc_int_sel, wdt_en, wdt_tick;
    logic port_od, port_pullup, mon_en;
    logic [15:0] pc_init;
    logic [7:0]  port_latch, reset_cause_register;
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    // Pin, monitor, pin again: back-to-back shows flags being replaced
    rsc_row_s rows [3] = '{'{1'b0, 8'h01, 1'b1}, '{1'b1, 8'h04, 1'b0}, '{1'b0, 8'h01, 1'b1}};

    rsc_supply_model #(.RAMP(5)) model_u (.ref_clk(ref_clk), .pwr_on(pwr_on), .sag(sag),
        .ext_low(ext_low), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .supply_ok(supply_ok), .por_det(por_det), .rst_pin_in(rst_pin_in));

    rsc_reset_source_controller #(.POR_DELAY(PD)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
        .clk_en(clk_en), .supply_ok(supply_ok), .por_det(por_det), .rst_pin_in(rst_pin_in),
        .mon_en_set(mon_en_set), .mon_en_clr(mon_en_clr), .rst_pin_out(rst_pin_out),
        .rst_pin_oe_n(rst_pin_oe_n), .core_run(core_run), .regs_rst(regs_rst),
        .irq_tmr_dis(irq_tmr_dis), .sp_rst(sp_rst), .mem_hold(mem_hold), .pc_init(pc_init),
        .osc_int_sel(osc_int_sel), .wdt_en(wdt_en), .wdt_tick(wdt_tick),
        .port_latch(port_latch), .port_od(port_od), .port_pullup(port_pullup),
        .mon_en(mon_en), .reset_cause_register(reset_cause_register));

    // ==========================================================
    // Helpers
    // ==========================================================
    // Single compare point; case inequality so an unknown never matches
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bounded wait for core_run to reach a level, cycles counted in n
    task automatic wait_core(input logic lvl);
        n = 0;
        while (core_run !== lvl && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 200) chk(16'h0, 16'h1, "core_run wait timed out");
    endtask

    // Outputs expected while held in reset
    task automatic held(input logic oe_n);
        chk(core_run, 1'b0, "core running in reset");
        chk({irq_tmr_dis, regs_rst}, 2'b11, "regs or timers live");
        chk({sp_rst, mem_hold}, 2'b11, "stack or memory guard");
        chk({port_latch, port_od, port_pullup}, 10'h3ff, "port state");
        chk({rst_pin_out, rst_pin_oe_n}, {1'b0, oe_n}, "reset pin drive");
    endtask

    // Outputs expected once released
    task automatic run_chk(input logic [7:0] cause);
        chk(pc_init, 16'h0000, "fetch address");
        chk(osc_int_sel, 1'b1, "clock source");
        chk(wdt_en, 1'b1, "watchdog enable");
        chk({port_pullup, rst_pin_oe_n}, 2'b11, "pullup or pin drive");
        chk(reset_cause_register, cause, "cause flags");
    endtask

    // ==========================================================
    // Clock, common-edge monitor, watchdog
    // ==========================================================
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Register, stack-pointer and watchdog controls must switch on the same edge as core_run
    always @(negedge ref_clk) begin
        if (rstn === 1'b1) chk({regs_rst, sp_rst, wdt_en}, {~core_run, ~core_run, core_run},
            "controls split from core_run");
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rstn, mon_en_set, mon_en_clr, pwr_on, sag, ext_low} = '0;
        clk_en = 1'b1;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        pwr_on <= 1'b1;
        @(negedge ref_clk);
        held(1'b0);
        // Power-on: release a full delay after the threshold is crossed
        while (supply_ok !== 1'b1) @(negedge ref_clk);
        wait_core(1'b1);
        chk(n >= PD && n <= PD + 8, 1'b1, "power-on release time");
        run_chk(8'h02);
        chk(mon_en, 1'b0, "monitor after power-on");
        // Watchdog prescaler period
        while (wdt_tick !== 1'b1) @(negedge ref_clk);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (wdt_tick !== 1'b1 && n < 40);
        chk(n, 12, "watchdog tick period");
        @(posedge ref_clk);
        mon_en_set <= 1'b1;
        @(posedge ref_clk);
        mon_en_set <= 1'b0;
        // Table of ordinary resets
        foreach (rows[i]) begin
            @(posedge ref_clk);
            if (rows[i].mon) sag <= 1'b1;
            else ext_low <= 1'b1;
            wait_core(1'b0);
            repeat (2) @(negedge ref_clk);
            held(rows[i].oe_n);
            @(posedge ref_clk);
            sag <= 1'b0;
            ext_low <= 1'b0;
            wait_core(1'b1);
            chk(n <= 8, 1'b1, "release without delay");
            run_chk(rows[i].cause);
            chk(mon_en, 1'b1, "monitor kept by other resets");
        end
        // Monitor disabled: a sag must not reset
        @(posedge ref_clk);
        mon_en_clr <= 1'b1;
        @(posedge ref_clk);
        mon_en_clr <= 1'b0;
        sag <= 1'b1;
        repeat (10) @(negedge ref_clk);
        chk({core_run, mon_en, reset_cause_register}, 10'h201, "sag with monitor off");
        @(posedge ref_clk);
        sag <= 1'b0;
        // Clock enable low freezes the sequencer against a pin press
        clk_en <= 1'b0;
        ext_low <= 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(core_run, 1'b1, "frozen sequencer");
        @(posedge ref_clk);
        ext_low <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b1;
        // Second reset in mid-run counts as power-on
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(negedge ref_clk);
        held(1'b0);
        chk({mon_en, reset_cause_register}, 9'h000, "cause during reset");
        @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        wait_core(1'b1);
        chk(n >= PD, 1'b1, "power-on delay after reset");
        run_chk(8'h02);
        chk(mon_en, 1'b0, "monitor after second power-on");
        end_of_test();
    end
endmodule // tb_top
